// ===== sif_fetch_unit.sv
// Script instruction fetch unit: prefetch buffer, burst op-code fetch, internal RAM
`timescale 1ns/1ps
`include "sif_defines.svh"
module sif_fetch_unit
   import sif_pkg::*;
(
   // Clock, reset, enable
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Strap pin
   input wire logic ram_enable_strap,
   // Execution engine fetch requests
   input wire logic ex_req_valid,
   input sif_ex_req_t ex_req,
   output logic ex_busy,
   output logic ex_dvalid,
   output logic [31:0] ex_data,
   output logic ex_done,
   // Execution engine flush events
   input wire logic ex_move_done,
   input wire logic ex_move_noflush,
   input wire logic ex_store_done,
   input wire logic ex_store_noflush,
   input wire logic ex_ctl_taken,
   // PCI master request side
   output logic pm_req_valid,
   output sif_pm_req_t pm_req,
   input wire logic pm_ready,
   input wire logic pm_rvalid,
   input wire logic [31:0] pm_rdata,
   // PCI target access to internal RAM
   input wire logic tgt_valid,
   input sif_tgt_req_t tgt_req,
   output logic tgt_ack,
   output logic [31:0] tgt_rdata
);

   // Prefetch block length from burst code (2 << code dwords), capped at eight
   function automatic logic [3:0] sif_pf_len(input logic [2:0] code);
      if (code >= 3'h2) begin
         return `SIF_PF_DWORDS;
      end else if (code == 3'h1) begin
         return `SIF_PF_MIN_DWORDS;
      end
      return 4'h2;
   endfunction

   // Block-aligned byte address for a block of len dwords
   function automatic logic [31:0] sif_blk(input logic [31:0] a, input logic [3:0] len);
      logic [31:0] mask;
      mask = {26'h0, len, 2'h0} - 32'h1;
      return a & ~mask;
   endfunction

   // Register state
   logic [7:0] dma_burst_mode_q;
   logic [7:0] dma_control_reg_q;
   logic [7:0] chip_test_two_q;
   logic [31:0] ip_q;
   logic [31:0] scratch_q;
   logic [31:0] ram_base_q;
   logic flush_reg_q;
   logic ahb_pend_q;
   logic ahb_wr_q;
   logic [7:0] ahb_addr_q;
   logic [31:0] rd_mux;
   // Strap capture
   logic strap_s1_q;
   logic strap_s2_q;
   logic strap_s3_q;
   logic strap_done_q;
   logic [1:0] strap_age_q;
   logic ram_en_q;
   // Fetch engine
   sif_state_t st_q;
   logic [31:0] cur_q;
   logic [2:0] rem_q;
   sif_kind_t kind_q;
   logic fill_q;
   logic stale_q;
   logic [3:0] cnt_q;
   logic pf_valid_q;
   logic [31:0] pf_tag_q;
   logic [3:0] pf_blen_q;
   logic [31:0] pf_buf [0:7];
   logic [31:0] ram_q [0:`SIF_RAM_WORDS-1];
   logic [1:0] tgt_wait_q;
   logic tgt_fire;
   logic flush;
   logic [3:0] pf_len;
   logic pf_on;
   logic ram_hit;
   logic buf_hit;
   logic [2:0] buf_idx;

   // Fetch mode decode
   assign pf_len = sif_pf_len(dma_burst_mode_q[`SIF_DMA_BURST_MODE_BL_MSB:`SIF_DMA_BURST_MODE_BL_LSB]);
   assign pf_on = dma_control_reg_q[`SIF_DMA_CONTROL_REG_PFEN_BIT] && (pf_len >= `SIF_PF_MIN_DWORDS);
   assign ram_hit = ram_en_q && (cur_q[31:12] == ram_base_q[31:12]);
   assign buf_hit = pf_valid_q && !flush && (sif_blk(cur_q, pf_blen_q) == pf_tag_q);
   assign buf_idx = cur_q[4:2] & (pf_blen_q[2:0] - 3'h1);
   // Flush sources merged into one pulse
   assign flush = flush_reg_q
      || (ex_move_done && !ex_move_noflush)
      || (ex_store_done && !ex_store_noflush)
      || ex_ctl_taken;

   // Register read multiplexer
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (ahb_addr_q)
         `SIF_OFS_CHIP_TEST_TWO: rd_mux = {24'h0, chip_test_two_q};
         `SIF_OFS_INSTR_PTR: rd_mux = ip_q;
         `SIF_OFS_DMA_BURST_MODE: rd_mux = {24'h0, dma_burst_mode_q};
         `SIF_OFS_DMA_CONTROL: rd_mux = {24'h0, dma_control_reg_q};
         `SIF_OFS_SCRATCH_TWO: begin
            if (chip_test_two_q[`SIF_CHIP_TEST_TWO_RBSEL_BIT]) begin
               rd_mux = ram_base_q;
            end else begin
               rd_mux = scratch_q;
            end
         end
         `SIF_OFS_RAM_BASE: rd_mux = ram_base_q;
         `SIF_OFS_STATUS: rd_mux = {23'h0, st_q, ex_busy, ram_en_q, pf_valid_q, pf_on};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // AHB slave: one wait state, then write or read data
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ahb_pend_q <= 1'b0;
         ahb_wr_q <= 1'b0;
         ahb_addr_q <= 8'h00;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h0000_0000;
         dma_burst_mode_q <= `SIF_DMA_BURST_MODE_RST;
         dma_control_reg_q <= `SIF_DMA_CONTROL_REG_RST;
         chip_test_two_q <= `SIF_CHIP_TEST_TWO_RST;
         ip_q <= 32'h0000_0000;
         scratch_q <= 32'h0000_0000;
         ram_base_q <= `SIF_RAM_BASE_RST;
         flush_reg_q <= 1'b0;
      end else if (ce) begin
         flush_reg_q <= 1'b0;
         if (ahb_pend_q) begin
            ahb_pend_q <= 1'b0;
            hreadyout <= 1'b1;
            if (ahb_wr_q) begin
               case (ahb_addr_q)
                  `SIF_OFS_CHIP_TEST_TWO: chip_test_two_q <= hwdata[7:0];
                  `SIF_OFS_INSTR_PTR: begin
                     ip_q <= hwdata;
                     flush_reg_q <= 1'b1;
                  end
                  `SIF_OFS_DMA_BURST_MODE: dma_burst_mode_q <= hwdata[7:0];
                  `SIF_OFS_DMA_CONTROL: begin
                     dma_control_reg_q <= hwdata[7:0] & ~(8'h01 << `SIF_DMA_CONTROL_REG_PFF_BIT);
                     flush_reg_q <= hwdata[`SIF_DMA_CONTROL_REG_PFF_BIT];
                  end
                  `SIF_OFS_SCRATCH_TWO: scratch_q <= hwdata;
                  `SIF_OFS_RAM_BASE: ram_base_q <= {hwdata[31:12], 12'h000};
                  default: hrdata <= 32'h0000_0000;
               endcase
            end else begin
               hrdata <= rd_mux;
            end
         end else if (hsel && htrans[1] && hready) begin
            ahb_pend_q <= 1'b1;
            ahb_wr_q <= hwrite;
            ahb_addr_q <= {haddr[7:2], 2'h0};
            hreadyout <= 1'b0;
         end
      end
   end

   // Strap sampling after reset release; pull-up default keeps RAM on
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         strap_s1_q <= 1'b1;
         strap_s2_q <= 1'b1;
         strap_s3_q <= 1'b1;
         strap_done_q <= 1'b0;
         strap_age_q <= 2'h0;
         ram_en_q <= 1'b1;
      end else if (ce) begin
         strap_s1_q <= ram_enable_strap;
         strap_s2_q <= strap_s1_q;
         strap_s3_q <= strap_s2_q;
         // Reset values agree trivially; wait until the pin has reached stage three
         if (strap_age_q != 2'h3) begin
            strap_age_q <= strap_age_q + 2'h1;
         end
         if (!strap_done_q && (strap_age_q == 2'h3) && (strap_s2_q == strap_s3_q)) begin
            strap_done_q <= 1'b1;
            ram_en_q <= strap_s3_q;
         end
      end
   end

   // Fetch state machine
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= SIF_ST_IDLE;
         cur_q <= 32'h0000_0000;
         rem_q <= 3'h0;
         kind_q <= SIF_KIND_INSTR;
         fill_q <= 1'b0;
         stale_q <= 1'b0;
         cnt_q <= 4'h0;
         pf_valid_q <= 1'b0;
         pf_tag_q <= 32'h0000_0000;
         pf_blen_q <= `SIF_PF_DWORDS;
         ex_busy <= 1'b0;
         ex_dvalid <= 1'b0;
         ex_data <= 32'h0000_0000;
         ex_done <= 1'b0;
         pm_req_valid <= 1'b0;
         pm_req <= '0;
      end else if (ce) begin
         ex_dvalid <= 1'b0;
         ex_done <= 1'b0;
         if (flush) begin
            pf_valid_q <= 1'b0;
            if (fill_q) begin
               stale_q <= 1'b1;
            end
         end
         case (st_q)
            SIF_ST_IDLE: begin
               if (ex_req_valid) begin
                  cur_q <= ex_req.addr;
                  rem_q <= ex_req.cnt;
                  kind_q <= ex_req.kind;
                  ex_busy <= 1'b1;
                  st_q <= SIF_ST_LOOK;
               end
            end
            SIF_ST_LOOK: begin
               if (rem_q == 3'h0) begin
                  ex_done <= 1'b1;
                  ex_busy <= 1'b0;
                  st_q <= SIF_ST_IDLE;
               end else if (ram_hit && (kind_q != SIF_KIND_DATA)) begin
                  st_q <= SIF_ST_RAMRD;
               end else if (pf_on && (kind_q != SIF_KIND_DATA)) begin
                  if (buf_hit) begin
                     ex_data <= pf_buf[buf_idx];
                     ex_dvalid <= 1'b1;
                     cur_q <= cur_q + 32'h4;
                     rem_q <= rem_q - 3'h1;
                  end else begin
                     pm_req.addr <= sif_blk(cur_q, pf_len);
                     pm_req.len <= {4'h0, pf_len};
                     pm_req.cmd <= `SIF_PCI_CMD_MEMRD;
                     fill_q <= 1'b1;
                     stale_q <= 1'b0;
                     pm_req_valid <= 1'b1;
                     st_q <= SIF_ST_PCIRQ;
                  end
               end else begin
                  // Data moves and unbuffered fetches; RAM hits of data go out too
                  pm_req.addr <= cur_q;
                  if (dma_burst_mode_q[`SIF_DMA_BURST_MODE_BOF_BIT] && (kind_q != SIF_KIND_DATA)
                      && (rem_q >= 3'h2)) begin
                     pm_req.len <= 8'h02;
                  end else begin
                     pm_req.len <= 8'h01;
                  end
                  pm_req.cmd <= `SIF_PCI_CMD_MEMRD;
                  fill_q <= 1'b0;
                  stale_q <= 1'b0;
                  pm_req_valid <= 1'b1;
                  st_q <= SIF_ST_PCIRQ;
               end
            end
            SIF_ST_RAMRD: begin
               ex_data <= ram_q[cur_q[11:2]];
               ex_dvalid <= 1'b1;
               cur_q <= cur_q + 32'h4;
               rem_q <= rem_q - 3'h1;
               st_q <= SIF_ST_LOOK;
            end
            SIF_ST_PCIRQ: begin
               if (pm_ready) begin
                  pm_req_valid <= 1'b0;
                  cnt_q <= 4'h0;
                  st_q <= SIF_ST_PCIDT;
               end
            end
            SIF_ST_PCIDT: begin
               if (pm_rvalid) begin
                  cnt_q <= cnt_q + 4'h1;
                  if (!fill_q) begin
                     ex_data <= pm_rdata;
                     ex_dvalid <= 1'b1;
                     cur_q <= cur_q + 32'h4;
                     rem_q <= rem_q - 3'h1;
                  end
                  if (cnt_q == (pm_req.len[3:0] - 4'h1)) begin
                     if (fill_q && !stale_q && !flush) begin
                        pf_valid_q <= 1'b1;
                        pf_tag_q <= pm_req.addr;
                        pf_blen_q <= pm_req.len[3:0];
                     end
                     fill_q <= 1'b0;
                     st_q <= SIF_ST_LOOK;
                  end
               end
            end
            default: st_q <= SIF_ST_IDLE;
         endcase
      end
   end

   // Prefetch buffer storage
   always_ff @(posedge hclk) begin
      if (ce && (st_q == SIF_ST_PCIDT) && pm_rvalid && fill_q) begin
         pf_buf[cnt_q[2:0]] <= pm_rdata;
      end
   end

   // PCI target access to RAM fires after three wait cycles
   assign tgt_fire = tgt_valid && !tgt_ack && (tgt_wait_q == `SIF_RAM_WAIT);

   // Target wait counter and answer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tgt_wait_q <= 2'h0;
         tgt_ack <= 1'b0;
         tgt_rdata <= 32'h0000_0000;
      end else if (ce) begin
         tgt_ack <= 1'b0;
         if (tgt_valid && !tgt_ack) begin
            if (tgt_fire) begin
               tgt_wait_q <= 2'h0;
               tgt_ack <= 1'b1;
               if (ram_en_q) begin
                  tgt_rdata <= ram_q[tgt_req.idx];
               end else begin
                  tgt_rdata <= 32'h0000_0000;
               end
            end else begin
               tgt_wait_q <= tgt_wait_q + 2'h1;
            end
         end else begin
            tgt_wait_q <= 2'h0;
         end
      end
   end

   // Byte-granular RAM writes
   always_ff @(posedge hclk) begin
      if (ce && tgt_fire && tgt_req.wr && ram_en_q) begin
         for (int b = 0; b < 4; b++) begin
            if (tgt_req.be[b]) begin
               ram_q[tgt_req.idx][b*8 +: 8] <= tgt_req.wdata[b*8 +: 8];
            end
         end
      end
   end

endmodule // sif_fetch_unit

// ===== sif_defines.svh
// Offsets, field positions, reset values and fixed counts of the fetch unit
`ifndef SIF_DEFINES_SVH
`define SIF_DEFINES_SVH
`define SIF_OFS_CHIP_TEST_TWO 8'h1C
`define SIF_OFS_INSTR_PTR 8'h2C
`define SIF_OFS_DMA_BURST_MODE 8'h38
`define SIF_OFS_DMA_CONTROL 8'h3C
`define SIF_OFS_SCRATCH_TWO 8'h5C
`define SIF_OFS_RAM_BASE 8'h60
`define SIF_OFS_STATUS 8'h64
`define SIF_DMA_BURST_MODE_BL_MSB 7
`define SIF_DMA_BURST_MODE_BL_LSB 5
`define SIF_DMA_BURST_MODE_BOF_BIT 1
`define SIF_DMA_CONTROL_REG_PFEN_BIT 5
`define SIF_DMA_CONTROL_REG_PFF_BIT 6
`define SIF_CHIP_TEST_TWO_RBSEL_BIT 3
`define SIF_DMA_BURST_MODE_RST 8'h00
`define SIF_DMA_CONTROL_REG_RST 8'h00
`define SIF_CHIP_TEST_TWO_RST 8'h00
`define SIF_RAM_BASE_RST 32'h0000_0000
`define SIF_PF_DWORDS 4'h8
`define SIF_PF_MIN_DWORDS 4'h4
`define SIF_RAM_WORDS 1024
`define SIF_RAM_WAIT 2'h3
`define SIF_PCI_CMD_MEMRD 4'h6
`endif

// ===== sif_pkg.sv
// Types shared by the script instruction fetch unit
package sif_pkg;
   typedef enum logic [4:0] {
      SIF_ST_IDLE  = 5'b00001,
      SIF_ST_LOOK  = 5'b00010,
      SIF_ST_RAMRD = 5'b00100,
      SIF_ST_PCIRQ = 5'b01000,
      SIF_ST_PCIDT = 5'b10000
   } sif_state_t;
   typedef enum logic [1:0] {
      SIF_KIND_INSTR = 2'h0,
      SIF_KIND_TABLE = 2'h1,
      SIF_KIND_DATA  = 2'h2
   } sif_kind_t;
   typedef struct packed {
      logic [31:0] addr;
      logic [2:0] cnt;
      sif_kind_t kind;
   } sif_ex_req_t;
   typedef struct packed {
      logic [31:0] addr;
      logic [7:0] len;
      logic [3:0] cmd;
   } sif_pm_req_t;
   typedef struct packed {
      logic wr;
      logic [9:0] idx;
      logic [3:0] be;
      logic [31:0] wdata;
   } sif_tgt_req_t;
endpackage

// ===== sif_fetch_props.sv
// Port checker for the script instruction fetch unit
`timescale 1ns/1ps
`include "sif_defines.svh"
module sif_fetch_props
   import sif_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Register bus
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   // Engine side
   input wire logic ex_busy,
   input wire logic ex_dvalid,
   input wire logic ex_done,
   // PCI master and RAM target
   input wire logic pm_req_valid,
   input sif_pm_req_t pm_req,
   input wire logic pm_ready,
   input wire logic tgt_valid,
   input wire logic tgt_ack
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // One wait state, then ready again
   sequence s_one_wait;
      !hreadyout ##1 hreadyout;
   endsequence
   // Three target wait states before the acknowledge
   sequence s_ram_wait;
      !tgt_ack [*3] ##[1:2] tgt_ack;
   endsequence
   a_ahb_one_wait: assert property (hsel && htrans[1] && hready && hreadyout |=> s_one_wait)
      else $error("register access wait state wrong");
   a_rdata_stands: assert property (!$rose(hreadyout) |-> $stable(hrdata))
      else $error("read data moved outside a completion");
   a_plain_read: assert property (pm_req_valid |-> pm_req.cmd == `SIF_PCI_CMD_MEMRD)
      else $error("fetch used a cache line command");
   a_req_held: assert property (pm_req_valid && !pm_ready |=> pm_req_valid && $stable(pm_req))
      else $error("master request changed before accept");
   a_len_legal: assert property (pm_req_valid |-> pm_req.len inside {8'h1, 8'h2, 8'h4, 8'h8})
      else $error("master burst length not supported");
   a_block_aligned: assert property (pm_req_valid && pm_req.len == 8'h8 |-> pm_req.addr[4:0] == 5'h0)
      else $error("eight dword fill not aligned");
   a_quad_aligned: assert property (pm_req_valid && pm_req.len == 8'h4 |-> pm_req.addr[3:0] == 4'h0)
      else $error("four dword fill not aligned");
   a_ram_wait: assert property ($rose(tgt_valid) |-> s_ram_wait)
      else $error("RAM target wait states wrong");
   a_data_in_busy: assert property (ex_dvalid |-> ex_busy)
      else $error("dword delivered with no request");
   a_done_pulse: assert property (ex_done |=> !ex_done && !ex_dvalid)
      else $error("done not a single pulse");
endmodule // sif_fetch_props
bind sif_fetch_unit sif_fetch_props sif_fetch_props_i (.hclk, .hresetn, .hsel, .htrans, .hready,
   .hreadyout, .hrdata, .ex_busy, .ex_dvalid, .ex_done, .pm_req_valid, .pm_req, .pm_ready,
   .tgt_valid, .tgt_ack);

// ===== sif_pci_mem_model.sv
// Host memory model answering the fetch unit's PCI read requests
`timescale 1ns/1ps
module sif_pci_mem_model
   import sif_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Request and answer
   input wire logic pm_req_valid,
   input sif_pm_req_t pm_req,
   output logic pm_ready,
   output logic pm_rvalid,
   output logic [31:0] pm_rdata,
   // Latency control and trace
   input wire logic [1:0] slow,
   output logic [15:0] req_cnt,
   output logic [7:0] last_len,
   output logic [31:0] last_addr
);
   logic [31:0] a;
   logic [7:0] n;
   // Quiet bus at time zero
   initial begin
      pm_ready = 1'b0;
      pm_rvalid = 1'b0;
      pm_rdata = 32'h0;
      req_cnt = 16'h0;
   end
   // Accept one request, then stream its dwords
   always begin
      @(posedge hclk);
      if (hresetn === 1'b1 && pm_req_valid === 1'b1) begin
         repeat (slow) @(posedge hclk);
         a = pm_req.addr;
         n = pm_req.len;
         pm_ready <= 1'b1;
         req_cnt <= req_cnt + 16'h1;
         last_len <= n;
         last_addr <= a;
         @(posedge hclk);
         pm_ready <= 1'b0;
         repeat (n) begin
            pm_rvalid <= 1'b1;
            pm_rdata <= ~a; // Content is the inverted address
            a = a + 32'h4;
            @(posedge hclk);
         end
         pm_rvalid <= 1'b0;
         pm_rdata <= ~pm_rdata; // No stale dword on idle bus
      end
   end
endmodule // sif_pci_mem_model

// ===== sif_fetch_unit_tb.sv
// Self-checking bench for the script instruction fetch unit
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
   $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module sif_fetch_unit_tb;
   import sif_pkg::*;
   logic hclk = 0, hresetn = 0, hsel = 1, hwrite = 0, strap = 1, ex_req_valid = 0, tgt_valid = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, ex_data, pm_rdata, tgt_rdata, last_addr, r;
   logic [1:0] htrans = 0, slow = 0;
   logic [4:0] ev = 0;
   logic hreadyout, hresp, ex_busy, ex_dvalid, ex_done, pm_req_valid, pm_ready, pm_rvalid, tgt_ack;
   logic [15:0] req_cnt, n0;
   logic [7:0] last_len;
   sif_ex_req_t ex_req = '0;
   sif_tgt_req_t tgt_req = '0;
   sif_pm_req_t pm_req;
   int n_mismatch = 0, tests_run = 0, cyc = 0, i;
   localparam logic [24:0] FL = {5'h10, 5'h0C, 5'h04, 5'h03, 5'h01};
   localparam logic [6:0] REFETCH = 7'b1110101;
   sif_fetch_unit sif_fetch_unit_i (.hclk, .hresetn, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
      .ram_enable_strap(strap), .ex_req_valid, .ex_req, .ex_busy, .ex_dvalid, .ex_data, .ex_done,
      .ex_move_done(ev[0]), .ex_move_noflush(ev[1]), .ex_store_done(ev[2]),
      .ex_store_noflush(ev[3]), .ex_ctl_taken(ev[4]), .pm_req_valid, .pm_req, .pm_ready,
      .pm_rvalid, .pm_rdata, .tgt_valid, .tgt_req, .tgt_ack, .tgt_rdata);
   sif_pci_mem_model sif_pci_mem_model_i (.hclk, .hresetn, .pm_req_valid, .pm_req, .pm_ready,
      .pm_rvalid, .pm_rdata, .slow, .req_cnt, .last_len, .last_addr);
   // Clock and cycle limit
   always #12.5 hclk = ~hclk;
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   // Counts, verdict and end of run
   task give_verdict;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // One AHB-Lite single word transfer
   task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge hclk);
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   // Internal RAM target access
   task tgt(input logic w, input logic [9:0] x, input logic [3:0] b, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge hclk);
      tgt_valid <= 1'b1;
      tgt_req <= '{w, x, b, d};
      do @(posedge hclk); while (tgt_ack !== 1'b1);
      q = tgt_rdata;
      tgt_valid <= 1'b0;
      @(posedge hclk);
   endtask
   // Engine fetch, every dword checked against the inverted address
   task fetch(input logic [31:0] a, input logic [2:0] c, input sif_kind_t k);
      logic [31:0] e;
      e = a;
      n0 = req_cnt;
      @(posedge hclk);
      ex_req_valid <= 1'b1;
      ex_req <= '{a, c, k};
      @(posedge hclk);
      ex_req_valid <= 1'b0;
      do begin
         @(posedge hclk);
         if (ex_dvalid === 1'b1) begin
            `CHK(ex_data, ~e)
            e = e + 32'h4;
         end
      end while (ex_done !== 1'b1);
      `CHK(e, a + {c, 2'b00})
   endtask
   // Main sequence
   initial begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(0, 8'h38, 32'h0, r);
      `CHK(r, 32'h0000_0000)
      ahb(1, 8'h38, 32'hFFFF_FFE2, r);
      ahb(0, 8'h38, 32'h0, r);
      `CHK(r, 32'h0000_00E2)
      ahb(1, 8'h3C, 32'h0000_0060, r);
      ahb(0, 8'h3C, 32'h0, r);
      `CHK(r, 32'h0000_0020)
      ahb(0, 8'h70, 32'h0, r);
      `CHK(r, 32'h0000_0000)
      `CHK(hresp, 1'b0)
      $display("register test done");
      ahb(1, 8'h3C, 32'h0, r);
      ahb(1, 8'h38, 32'h0000_0002, r);
      slow <= 2'h2;
      for (i = 0; i < 3; i++) begin
         fetch(32'h1000_0004, i + 2, (i == 2) ? SIF_KIND_TABLE : SIF_KIND_INSTR);
         `CHK(req_cnt - n0, (i == 0) ? 16'h1 : 16'h2)
         `CHK(last_len, (i == 1) ? 8'h1 : 8'h2)
      end
      slow <= 2'h0;
      $display("burst op-code test done");
      ahb(1, 8'h38, 32'h0000_0040, r);
      ahb(1, 8'h3C, 32'h0000_0020, r);
      for (i = 0; i < 7; i++) begin
         fetch(32'h2000_0008, 3'h2, SIF_KIND_INSTR);
         case (i)
            5: ahb(1, 8'h2C, 32'h2000_0008, r);
            6: ahb(1, 8'h3C, 32'h0000_0060, r);
            default: begin
               @(posedge hclk);
               ev <= FL[i * 5 +: 5];
               @(posedge hclk);
               ev <= 5'h00;
            end
         endcase
         repeat (3) @(posedge hclk);
         fetch(32'h2000_0008, 3'h2, SIF_KIND_INSTR);
         `CHK(req_cnt - n0, {15'h0, REFETCH[i]})
      end
      `CHK({last_len, last_addr}, {8'h8, 32'h2000_0000})
      ahb(1, 8'h38, 32'h0000_0020, r);
      ahb(1, 8'h3C, 32'h0000_0060, r);
      fetch(32'h2000_0018, 3'h1, SIF_KIND_INSTR);
      `CHK({last_len, last_addr}, {8'h4, 32'h2000_0010})
      ahb(1, 8'h38, 32'h0000_0000, r);
      ahb(1, 8'h3C, 32'h0000_0060, r);
      fetch(32'h2000_0040, 3'h1, SIF_KIND_INSTR);
      `CHK({req_cnt - n0, last_len}, {16'h1, 8'h1})
      $display("prefetch test done");
      ahb(1, 8'h3C, 32'h0, r);
      ahb(1, 8'h60, 32'h3000_0000, r);
      for (i = 0; i < 4; i++) tgt(1, i, 4'hF, ~(32'h3000_0000 + 4 * i), r);
      tgt(1, 10'h4, 4'hF, 32'h1234_5678, r);
      tgt(1, 10'h4, 4'h2, 32'h0000_AB00, r);
      tgt(0, 10'h4, 4'hF, 32'h0, r);
      `CHK(r, 32'h1234_AB78)
      fetch(32'h3000_0000, 3'h4, SIF_KIND_INSTR);
      `CHK(req_cnt - n0, 16'h0)
      fetch(32'h3000_0000, 3'h1, SIF_KIND_DATA);
      `CHK(req_cnt - n0, 16'h1)
      ahb(1, 8'h1C, 32'h0000_0008, r);
      ahb(0, 8'h5C, 32'h0, r);
      `CHK(r, 32'h3000_0000)
      $display("internal RAM test done");
      strap <= 1'b0;
      hresetn <= 1'b0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (6) @(posedge hclk);
      ahb(1, 8'h60, 32'h3000_0000, r);
      tgt(0, 10'h4, 4'hF, 32'h0, r);
      `CHK(r, 32'h0000_0000)
      fetch(32'h3000_0000, 3'h1, SIF_KIND_INSTR);
      `CHK(req_cnt - n0, 16'h1)
      $display("strap test done");
      give_verdict();
   end
endmodule // sif_fetch_unit_tb
